/* File: hdl/sarcc_defines.svh */
// Purpose: constants of the sar conversion control block
// Assumes: included by bare name, guard prevents double use
// Notes:   offsets, field positions, reset values and timing counts
`ifndef SARCC_DEFINES_SVH
`define SARCC_DEFINES_SVH

// ----------------------------------------
// word sizes
// ----------------------------------------
`define SARCC_CFG_BITS   8
`define SARCC_FULL_BITS  16
`define SARCC_RES_BITS   16
`define SARCC_LSB_IDX    (`SARCC_FULL_BITS - `SARCC_RES_BITS)
`define SARCC_ACQ_EDGE   6

// ----------------------------------------
// config word fields, first bit shifted in is bit 7
// ----------------------------------------
`define SARCC_F_MUX_HI   7
`define SARCC_F_MUX_LO   4
`define SARCC_F_UNI      3
`define SARCC_F_GAIN     2
`define SARCC_F_NAP      1
`define SARCC_F_SLEEP    0
`define SARCC_CFG_RST    8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define SARCC_CLK_NS     10
`define SARCC_T_CONV_NS  4000
`define SARCC_T_ACQ_NS   4000
`define SARCC_STEP_CYC   ((`SARCC_T_CONV_NS / `SARCC_CLK_NS) / `SARCC_FULL_BITS)

`endif

/* File: hdl/sarcc_pkg.sv */
// Purpose: types and helpers of the sar conversion control block
// Assumes: sarcc_defines.svh holds every number
// Notes:   one state struct per clock domain or edge
`include "sarcc_defines.svh"

package sarcc_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} sarcc_state_t;

	typedef struct packed {
		logic [2:0]                            trg_s;
		logic [2:0]                            rd_s;
		logic [2:0]                            cfg_s;
		logic [2:0]                            acq_s;
		logic [2:0]                            mid_s;
		logic                                  trg_l;
		logic                                  rd_l;
		logic                                  cfg_l;
		logic                                  acq_l;
		logic                                  mid_l;
		logic [`SARCC_CFG_BITS-1:0]            cfg_rx;
		logic [`SARCC_CFG_BITS-1:0]            cfg_act;
		sarcc_state_t                          state;
		logic [4:0]                            step;
		logic [3:0]                            bidx;
		logic [`SARCC_FULL_BITS-1:0]           sar;
		logic                                  track;
		logic                                  busy_n;
		logic                                  link_clr;
		logic [1:0][`SARCC_FULL_BITS-1:0]      mem;
		logic                                  wp;
		logic                                  rp;
		logic [1:0]                            cnt;
		logic [`SARCC_FULL_BITS-1:0]           result;
	} sarcc_sys_t;

	typedef struct packed {
		logic [3:0]                 cnt;
		logic [`SARCC_CFG_BITS-1:0] word;
		logic                       full;
	} sarcc_rise_t;

	typedef struct packed {
		logic [4:0] cnt;
		logic       acq;
		logic       mid;
	} sarcc_fall_t;

	// new level counts only once stages two and three agree
	function automatic logic sarcc_agree(input logic [2:0] s, input logic l);
		return (s[2] == s[1]) ? s[2] : l;
	endfunction : sarcc_agree

	// offset binary from the sar, msb flipped for two's complement
	function automatic logic [`SARCC_FULL_BITS-1:0] sarcc_code(
		input logic [`SARCC_FULL_BITS-1:0] sar,
		input logic                        uni);
		logic [`SARCC_FULL_BITS-1:0] c;
		c = sar;
		if (!uni) begin
			c[`SARCC_FULL_BITS-1] = ~sar[`SARCC_FULL_BITS-1];
		end
		return c & ~((`SARCC_FULL_BITS'(1) << `SARCC_LSB_IDX) - `SARCC_FULL_BITS'(1));
	endfunction : sarcc_code

endpackage : sarcc_pkg

/* File: hdl/sarcc_top.sv */
// Purpose: control logic of an eight channel sar converter
// Assumes: sck is the host's shift clock, still between frames
// Notes:   comparator and dac sit outside; comp_in is on sys_clk
// What this block does
// - result pin driven only while rd_n low
// - conversion starts on trigger rising edge only
// - first eight rising sck edges load config
// - tracking starts at falling edge after sixth
// - trigger edge ends tracking, holds the sample
// - trigger edges ignored while converting
// - sar decides one bit per step, msb first
// - finished sar word loads the output register
// - unipolar result is natural binary
// - bipolar result is two's complement
// - each conversion takes channel and range anew
// - busy_n low for the whole conversion
// - data changes on falling, sampled on rising
// - result returned in the following transfer
// - short builds shift zeros in trailing bits
`timescale 1ns/10ps
`include "sarcc_defines.svh"

module sarcc_top
	import sarcc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        sck,
	input  wire logic        conversion_trigger,
	input  wire logic        rd_n,
	input  wire logic        serial_config_in,
	input  wire logic        comp_in,
	output logic             serial_result_out,
	output logic             sdo_oe,
	output logic             busy_n,
	output logic             sh_track,
	output logic [15:0]      sar_trial,
	output logic [3:0]       mux_addr,
	output logic             uni,
	output logic             gain,
	output logic             nap,
	output logic             sleep
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	sarcc_sys_t                  sq;
	sarcc_sys_t                  sn;
	sarcc_rise_t                 rq;
	sarcc_rise_t                 rn;
	sarcc_fall_t                 fq;
	sarcc_fall_t                 fn;
	logic                        link_rst;
	logic                        trg_rise;
	logic                        push;
	logic                        pop;
	logic [`SARCC_FULL_BITS-1:0] push_word;

	localparam logic [4:0] STEP_LAST = 5'(`SARCC_STEP_CYC - 1);
	localparam logic [3:0] LSB_IDX   = 4'(`SARCC_LSB_IDX);
	localparam logic [3:0] MSB_IDX   = 4'(`SARCC_FULL_BITS - 1);

	// ----------------------------------------
	// system domain
	// ----------------------------------------
	always_comb begin
		sn        = sq;
		push      = 1'b0;
		pop       = 1'b0;
		push_word = sarcc_code(sq.sar, sq.cfg_act[`SARCC_F_UNI]);
		sn.trg_s  = {sq.trg_s[1:0], conversion_trigger};
		sn.rd_s   = {sq.rd_s[1:0], rd_n};
		sn.cfg_s  = {sq.cfg_s[1:0], rq.full};
		sn.acq_s  = {sq.acq_s[1:0], fq.acq};
		sn.mid_s  = {sq.mid_s[1:0], fq.mid};
		sn.trg_l  = sarcc_agree(sq.trg_s, sq.trg_l);
		sn.rd_l   = sarcc_agree(sq.rd_s, sq.rd_l);
		sn.cfg_l  = sarcc_agree(sq.cfg_s, sq.cfg_l);
		sn.acq_l  = sarcc_agree(sq.acq_s, sq.acq_l);
		sn.mid_l  = sarcc_agree(sq.mid_s, sq.mid_l);
		trg_rise  = sn.trg_l & ~sq.trg_l;
		// word is stable: it only changes after the next trigger
		if (sn.cfg_l && !sq.cfg_l) begin
			sn.cfg_rx = rq.word;
		end
		if (sn.acq_l && !sq.acq_l) begin
			sn.track = 1'b1;
		end
		unique case (sq.state)
			ST_IDLE: begin
				if (trg_rise) begin
					sn.cfg_act  = sq.cfg_rx;
					sn.track    = 1'b0;
					sn.busy_n   = 1'b0;
					sn.link_clr = 1'b1;
					sn.sar      = '0;
					sn.sar[MSB_IDX] = 1'b1;
					sn.bidx     = MSB_IDX;
					sn.step     = '0;
					sn.state    = ST_CONV;
				end
			end
			ST_CONV: begin
				// trigger edges fall through unused here
				sn.step = sq.step + 5'd1;
				if (sq.step == STEP_LAST) begin
					sn.step = '0;
					if (!comp_in) begin
						sn.sar[sq.bidx] = 1'b0;
					end
					if (sq.bidx == LSB_IDX) begin
						sn.state = ST_DONE;
					end else begin
						sn.bidx = sq.bidx - 4'd1;
						sn.sar[sq.bidx - 4'd1] = 1'b1;
					end
				end
			end
			ST_DONE: begin
				// a full buffer stalls completion, busy_n stays low
				if (sq.cnt != 2'd2) begin
					push        = 1'b1;
					sn.busy_n   = 1'b1;
					sn.link_clr = 1'b0;
					sn.state    = ST_IDLE;
				end
			end
		endcase
		// two-entry buffer; drained only between frames
		pop = (sq.cnt != 2'd0) && !sq.mid_l;
		if (push) begin
			sn.mem[sq.wp] = push_word;
			sn.wp         = ~sq.wp;
		end
		if (pop) begin
			sn.result = sq.mem[sq.rp];
			sn.rp     = ~sq.rp;
		end
		sn.cnt = sq.cnt + 2'(push) - 2'(pop);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sq        <= '0;
			sq.busy_n <= 1'b1;
			// rd_n idles high, so no false read enable comes out of reset
			sq.rd_s   <= 3'h7;
			sq.rd_l   <= 1'b1;
		end else begin
			sq <= sn;
		end
	end

	// ----------------------------------------
	// link domain
	// ----------------------------------------
	// held clear while converting, so every frame starts at bit zero
	assign link_rst = rst | sq.link_clr;

	always_comb begin
		rn = rq;
		if (rq.cnt != 4'(`SARCC_CFG_BITS)) begin
			rn.word = {rq.word[`SARCC_CFG_BITS-2:0], serial_config_in};
			rn.cnt  = rq.cnt + 4'd1;
			rn.full = (rq.cnt == 4'(`SARCC_CFG_BITS - 1));
		end
	end

	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst) begin
			rq <= '0;
		end else begin
			rq <= rn;
		end
	end

	always_comb begin
		fn = fq;
		if (fq.cnt != 5'(`SARCC_FULL_BITS)) begin
			fn.cnt = fq.cnt + 5'd1;
		end
		if (rq.cnt == 4'(`SARCC_ACQ_EDGE)) begin
			fn.acq = 1'b1;
		end
		fn.mid = (fn.cnt != 5'd0) && (fn.cnt != 5'(`SARCC_FULL_BITS));
	end

	always_ff @(negedge sck or posedge link_rst) begin
		if (link_rst) begin
			fq <= '0;
		end else begin
			fq <= fn;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// msb stands before the first falling edge; zeros after the word
	assign serial_result_out = fq.cnt[4] ? 1'b0 : sq.result[~fq.cnt[3:0]];
	assign sdo_oe            = ~sq.rd_l;
	assign busy_n            = sq.busy_n;
	assign sh_track          = sq.track;
	assign sar_trial         = sq.sar;
	assign mux_addr          = sq.cfg_act[`SARCC_F_MUX_HI:`SARCC_F_MUX_LO];
	assign uni               = sq.cfg_act[`SARCC_F_UNI];
	assign gain              = sq.cfg_act[`SARCC_F_GAIN];
	assign nap               = sq.cfg_act[`SARCC_F_NAP];
	assign sleep             = sq.cfg_act[`SARCC_F_SLEEP];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_start;
		(sq.state == ST_IDLE) && trg_rise;
	endsequence

	sequence s_decide;
		(sq.state == ST_CONV) && (sq.step == STEP_LAST) && (sq.bidx != LSB_IDX);
	endsequence

	sequence s_push_idle;
		push && (sq.cnt == 2'd0) && !sq.mid_l ##1 !sq.mid_l;
	endsequence

	sequence s_finish;
		(sq.state == ST_DONE) && (sq.cnt != 2'd2);
	endsequence

	AST_OE_FOLLOWS_RD: assert property (
		@(posedge sys_clk) disable iff (rst)
		(!rd_n) [*4] |=> sdo_oe)
		else $error("output enable not raised by low rd_n");

	AST_OE_RELEASE: assert property (
		@(posedge sys_clk) disable iff (rst)
		rd_n [*4] |=> !sdo_oe)
		else $error("output still enabled with rd_n high");

	AST_LEVEL_NO_START: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_IDLE) && !trg_rise |=> sq.state != ST_CONV)
		else $error("conversion started without a rising edge");

	AST_START_HOLD: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_start |=> !sh_track && (sq.state == ST_CONV) && (sq.bidx == MSB_IDX))
		else $error("trigger edge did not hold and start at msb");

	AST_BUSY_LOW: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_start |=> !busy_n [*8])
		else $error("busy_n rose early in a conversion");

	AST_BUSY_TRACKS_CONV: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_CONV) |-> !busy_n)
		else $error("busy_n high while converting");

	AST_NO_RESTART: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_CONV) && trg_rise && (sq.step != STEP_LAST)
		|=> (sq.state == ST_CONV) && $stable(sq.bidx))
		else $error("conversion restarted by trigger");

	AST_MSB_FIRST: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_decide |=> (sq.bidx == $past(sq.bidx) - 4'd1) && sar_trial[sq.bidx])
		else $error("sar step out of order");

	AST_ACQ_START: assert property (
		@(posedge sys_clk) disable iff (rst)
		$rose(sq.acq_l) && (sq.state == ST_IDLE) && !trg_rise |-> sh_track)
		else $error("tracking not entered after sixth edge");

	AST_CFG_FIXED: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state != ST_IDLE) |=> $stable(mux_addr) && $stable(uni) && $stable(gain))
		else $error("config changed during conversion");

	AST_CODE_UNI: assert property (
		@(posedge sys_clk) disable iff (rst)
		push && uni |-> push_word[15] == sq.sar[15])
		else $error("unipolar code not natural binary");

	AST_CODE_BIP: assert property (
		@(posedge sys_clk) disable iff (rst)
		push && !uni |-> push_word[15] != sq.sar[15])
		else $error("bipolar code msb not inverted");

	AST_LOAD: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_push_idle |=> sq.result == $past(push_word, 2))
		else $error("finished word not loaded for readout");

	AST_TRAIL_ZERO: assert property (
		@(posedge sys_clk) disable iff (rst)
		pop |=> (sq.result & ((16'h0001 << `SARCC_LSB_IDX) - 16'h0001)) == 16'h0000)
		else $error("trailing bits not zero");

	AST_BUSY_HIGH_IDLE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_IDLE) |-> busy_n)
		else $error("busy_n low while idle");

	AST_HOLD_IN_CONV: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_CONV) |-> !sh_track)
		else $error("tracking while converting");

	AST_FIRST_TRIAL: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_start |=> (sar_trial == 16'h8000) && (sq.step == 5'h00))
		else $error("first trial is not the msb alone");

	AST_STEP_ADVANCE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_CONV) && (sq.step != STEP_LAST)
		|=> (sq.step == $past(sq.step) + 5'h01) && $stable(sq.bidx))
		else $error("step count or bit index out of order");

	AST_LOWER_CLEAR: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_decide |=> (sar_trial & ((16'h0001 << sq.bidx) - 16'h0001)) == 16'h0000)
		else $error("bits below the trial bit not clear");

	AST_FINISH: assert property (
		@(posedge sys_clk) disable iff (rst)
		s_finish |-> push ##1 (busy_n && (sq.state == ST_IDLE)))
		else $error("finished word not pushed or busy_n not raised");

	AST_CFG_CAPTURE: assert property (
		@(posedge sys_clk) disable iff (rst)
		$rose(sq.cfg_l) |-> (sq.cfg_rx == rq.word))
		else $error("config word not captured");

	AST_LINK_CLEAR: assert property (
		@(posedge sys_clk) disable iff (rst)
		(sq.state == ST_CONV) |-> link_rst && (fq.cnt == 5'h00))
		else $error("link counters not held clear while converting");

endmodule : sarcc_top

/* File: sim/sarcc_host_model.sv */
// Purpose: host side of the serial link, shifts config in and result out
// Assumes: sck idles low and runs only inside a frame, 64 ns period
// Notes:   config line shows the inverse of its last bit between frames
`timescale 1ns/10ps

module sarcc_host_model (
	output logic      sck,
	output logic      serial_config_in,
	input  wire logic serial_result_out,
	input  wire logic sh_track
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic trk_seen;

	initial begin
		sck              = 1'b0;
		serial_config_in = 1'b1;
		trk_seen         = 1'b0;
	end

	// ----------------------------------------
	// one full duplex frame of 16 clocks
	// ----------------------------------------
	// trailing bits carry the inverse of the word so a late capture shows
	task automatic frame(input logic [7:0] cfg, output logic [15:0] res);
		logic [15:0] tx;
		tx  = {cfg, ~cfg};
		res = 16'h0000;
		for (int i = 15; i >= 0; i--) begin
			serial_config_in = tx[i];
			#32 sck = 1'b1;
			res[i] = serial_result_out;
			if (i == 8) begin
				trk_seen = sh_track;
			end
			#32 sck = 1'b0;
		end
		serial_config_in = ~tx[0];
	endtask : frame

endmodule : sarcc_host_model

/* File: sim/tb_sar_adc_conversion_control.sv */
// Purpose: self-checking bench of the sar conversion control block
// Assumes: comparator modelled as input level against the trial word
// Notes:   results compared one frame after their conversion
`timescale 1ns/10ps
`include "sarcc_defines.svh"

`define SARCC_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_sar_adc_conversion_control;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        sys_clk;
	logic        rst;
	logic        sck;
	logic        conversion_trigger;
	logic        rd_n;
	logic        serial_config_in;
	logic        comp_in;
	logic        serial_result_out;
	logic        sdo_oe;
	logic        busy_n;
	logic        sh_track;
	logic [15:0] sar_trial;
	logic [3:0]  mux_addr;
	logic        uni;
	logic        gain;
	logic        nap;
	logic        sleep;
	logic [15:0] ana_q;
	logic [15:0] prev_exp;
	logic        have_prev;
	int          err_total;
	int          samples_checked;

	sarcc_top u_sarcc_top (
		.sys_clk            (sys_clk),
		.rst                (rst),
		.sck                (sck),
		.conversion_trigger (conversion_trigger),
		.rd_n               (rd_n),
		.serial_config_in   (serial_config_in),
		.comp_in            (comp_in),
		.serial_result_out  (serial_result_out),
		.sdo_oe             (sdo_oe),
		.busy_n             (busy_n),
		.sh_track           (sh_track),
		.sar_trial          (sar_trial),
		.mux_addr           (mux_addr),
		.uni                (uni),
		.gain               (gain),
		.nap                (nap),
		.sleep              (sleep)
	);

	sarcc_host_model u_sarcc_host_model (
		.sck               (sck),
		.serial_config_in  (serial_config_in),
		.serial_result_out (serial_result_out),
		.sh_track          (sh_track)
	);

	// ideal comparator: keep the bit while the input reaches the trial
	assign comp_in = (sar_trial <= ana_q);

	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic run_conv(input logic [7:0] cfg, input logic [15:0] ana,
		input logic [15:0] exp, input logic retrig);
		logic [15:0] got;
		int          n;
		ana_q = ana;
		u_sarcc_host_model.frame(cfg, got);
		if (have_prev) begin
			`SARCC_CHK("result", prev_exp, got)
		end
		`SARCC_CHK("tracking", 1'b1, u_sarcc_host_model.trk_seen)
		// host keeps at least 4 us of tracking before the trigger
		repeat (410) @(posedge sys_clk);
		#1 conversion_trigger = 1'b1;
		repeat (8) @(posedge sys_clk);
		#1;
		`SARCC_CHK("busy_low", 1'b0, busy_n)
		`SARCC_CHK("hold", 1'b0, sh_track)
		`SARCC_CHK("fields", cfg, {mux_addr, uni, gain, nap, sleep})
		if (!retrig) begin
			conversion_trigger = 1'b0;
		end
		n = 0;
		while (busy_n !== 1'b1) begin
			@(posedge sys_clk);
			#1;
			n++;
			if (retrig && n == 50) conversion_trigger = 1'b0;
			if (retrig && n == 100) conversion_trigger = 1'b1;
			if (n > 600) begin
				err_total++;
				$display("mismatch busy_wait expected done seen timeout");
				tally_and_finish();
			end
		end
		`SARCC_CHK("conv_length", 1'b1, (n >= 390 && n <= 420))
		`SARCC_CHK("fields_kept", cfg, {mux_addr, uni, gain, nap, sleep})
		// a level still high afterwards must not start another conversion
		repeat (60) @(posedge sys_clk);
		#1;
		`SARCC_CHK("no_restart", 1'b1, busy_n)
		conversion_trigger = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		prev_exp  = exp;
		have_prev = 1'b1;
	endtask : run_conv

	task automatic t_read_enable;
		rd_n = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		`SARCC_CHK("oe_off", 1'b0, sdo_oe)
		rd_n = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		`SARCC_CHK("oe_on", 1'b1, sdo_oe)
		$display("test read_enable done");
	endtask : t_read_enable

	task automatic t_unipolar;
		run_conv(8'h3a, 16'ha5c3, 16'ha5c3, 1'b0);
		run_conv(8'hfc, 16'hffff, 16'hffff, 1'b0);
		run_conv(8'h09, 16'h0000, 16'h0000, 1'b0);
		$display("test unipolar done");
	endtask : t_unipolar

	task automatic t_bipolar;
		// just below zero and exactly zero, second one retriggered mid-run
		run_conv(8'h74, 16'h7fff, 16'hffff, 1'b0);
		run_conv(8'h82, 16'h8000, 16'h0000, 1'b1);
		$display("test bipolar done");
	endtask : t_bipolar

	task automatic t_last_read;
		logic [15:0] got;
		u_sarcc_host_model.frame(8'h00, got);
		`SARCC_CHK("last_result", prev_exp, got)
		$display("test last_read done");
	endtask : t_last_read

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_clk            = 1'b0;
		rst                = 1'b1;
		conversion_trigger = 1'b0;
		rd_n               = 1'b0;
		ana_q              = 16'h0000;
		prev_exp           = 16'h0000;
		have_prev          = 1'b0;
		err_total          = 0;
		samples_checked    = 0;
		repeat (4) @(posedge sys_clk);
		`SARCC_CHK("oe_reset", 1'b0, sdo_oe)
		`SARCC_CHK("busy_reset", 1'b1, busy_n)
		#1 rst = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		t_read_enable();
		t_unipolar();
		t_bipolar();
		t_last_read();
		tally_and_finish();
	end

endmodule : tb_sar_adc_conversion_control
